//--- hw/i2cwc_top.sv
// i2c target: wiper register, nonvolatile copy, write protect, tolerance
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - wiper starts at midscale from nonvolatile copy; srst loads WIPER_MIDSCALE into wiper and copy directly
// RULE2 - eight-bit code selects one of 256 taps
// RULE3 - sda fall while scl high starts frame
// RULE4 - first byte: seven-bit address, direction bit
// RULE5 - address pins sampled once after reset
// RULE6 - matching address acknowledged on ninth clock
// RULE7 - instruction: three command bits, five zeros
// RULE8 - data byte msb first, acknowledged
// RULE9 - write-protect data lsb sets protection
// RULE10 - store/restore carry no data byte
// RULE11 - store copies wiper; restore copies back
// RULE12 - master sends nop after restore
// RULE13 - master selects register before reading
// RULE14 - repeated start read returns selected byte
// RULE15 - read bits change on scl falling
// RULE16 - sda rise while scl high ends frame
// RULE17 - master nacks last read byte
// RULE18 - burst data bytes update wiper repeatedly
// RULE19 - new instruction needs new transaction
// RULE20 - repeated wiper reads allowed
// RULE21 - tolerance readable singly or consecutively
// RULE22 - command codes select the operation
// RULE23 - pin states map to fixed addresses
// RULE24 - write protect clears at power-up
// RULE25 - restore holds read power until nop
// RULE26 - protection blocks wiper and copy writes
// RULE27 - foreign address not acknowledged, sda released
module i2cwc_top
    import i2cwc_pkg::*;
#(
    parameter logic [7:0] TOLERANCE_BYTE = 8'h00
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_pin0,
    input wire logic addr_select_pin1,
    output logic [255:0] tap_select,
    output i2cwc_pkg::i2cwc_status_t status
);
    import i2cwc_pkg::*;

    i2cwc_regs_t r;
    i2cwc_regs_t n;

    function automatic logic [6:0] addr_of(input logic [1:0] p);
        case (p)
            2'b00: addr_of = ADDR_PIN00;
            2'b01: addr_of = ADDR_PIN01;
            2'b10: addr_of = ADDR_PIN10;
            default: addr_of = ADDR_PIN11;
        endcase
    endfunction

    function automatic logic [7:0] read_src(input i2cwc_regs_t q);
        case (q.cmd)
            CMD_NVCOPY: read_src = q.stat.nvcopy;
            CMD_TOL: read_src = TOLERANCE_BYTE;
            default: read_src = q.stat.wiper;
        endcase
    endfunction

    logic [7:0] rd_byte;
    assign rd_byte = read_src(r);
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
    assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
    // stage 0 of each synchroniser is read only by stage 1
    assign start_c = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1]; // RULE3
    assign stop_c = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1]; // RULE16

    always_comb
    begin
        n = r;
        n.scl_s = {r.scl_s[1:0], scl_in};
        n.sda_s = {r.sda_s[1:0], sda_in};
        n.pins1 = {addr_select_pin1, addr_select_pin0};
        n.pins2 = r.pins1;
        // pins settle through two stages before the one-time capture
        if (r.boot != 2'b11)
        begin
            n.boot = r.boot + 2'b01;
            if (r.boot == 2'b10)
            begin
                n.my_addr = addr_of(r.pins2); // RULE5 RULE23
            end
        end
        n.taps = 256'(1) << r.stat.wiper; // RULE2
        if (start_c)
        begin
            n.st = (r.boot == 2'b11) ? I2CWC_RUN : I2CWC_IDLE;
            // the scl fall that closes the start is not a data bit
            n.bitn = BIT_LAST;
            n.bytn = BYTE_ADDR;
            n.rd = 1'b0;
            n.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            n.st = I2CWC_IDLE; // RULE16
            n.sda_oe = 1'b0;
        end
        else if (r.st == I2CWC_RUN)
        begin
            if (scl_rise && r.bitn < BIT_ACK && !r.rd)
            begin
                n.sh = {r.sh[6:0], r.sda_s[1]}; // RULE8
            end
            if (scl_rise && r.bitn == BIT_ACK && r.rd)
            begin
                // master nack ends the read; ack keeps streaming
                if (r.sda_s[1])
                begin
                    n.st = I2CWC_SKIP; // RULE17
                end
            end
            if (scl_fall)
            begin
                n.bitn = (r.bitn == BIT_ACK || r.bitn == BIT_LAST) ? BIT_ZERO : r.bitn + 4'h1;
                n.sda_oe = 1'b0;
                if (r.bitn == 4'h7 && !r.rd)
                begin
                    case (r.bytn)
                        BYTE_ADDR:
                        begin
                            if (r.sh[7:1] == r.my_addr) // RULE4 RULE6
                            begin
                                n.sda_oe = 1'b1;
                                n.rd = r.sh[0];
                            end
                            else
                            begin
                                n.st = I2CWC_SKIP; // RULE27
                            end
                        end
                        BYTE_INSTR:
                        begin
                            n.cmd = r.sh[7:5]; // RULE7 RULE19
                            n.sda_oe = (r.sh[4:0] == 5'h00);
                            if (r.sh[4:0] != 5'h00)
                            begin
                                n.st = I2CWC_SKIP;
                            end
                            case (r.sh[7:5]) // RULE22 RULE10
                                CMD_STORE: n.stat.nvcopy = r.stat.wiper; // RULE11
                                CMD_RESTORE:
                                begin
                                    n.stat.wiper = r.stat.nvcopy; // RULE11
                                    n.stat.nv_read_power = 1'b1; // RULE25
                                end
                                CMD_NOP: n.stat.nv_read_power = 1'b0; // RULE25 RULE12
                                default: n.stat.nv_read_power = r.stat.nv_read_power;
                            endcase
                        end
                        default:
                        begin
                            n.sda_oe = 1'b1; // RULE8
                            case (r.cmd)
                                CMD_WIPER: if (!r.stat.wprot) n.stat.wiper = r.sh; // RULE18 RULE26
                                CMD_NVCOPY: if (!r.stat.wprot) n.stat.nvcopy = r.sh; // RULE26
                                CMD_WPROT: n.stat.wprot = r.sh[0]; // RULE9
                                default: n.stat.wprot = r.stat.wprot;
                            endcase
                        end
                    endcase
                    n.bytn = (r.bytn == BYTE_DATA) ? BYTE_DATA : r.bytn + 2'h1;
                end
                if (r.rd && r.bitn == BIT_ACK)
                begin
                    // our ack (after address) or master ack: reload and drive msb
                    n.bitn = BIT_ZERO;
                    n.sda_oe = ~rd_byte[7]; // RULE14 RULE20 RULE21
                    n.sh = {rd_byte[6:0], 1'b0};
                end
                else if (r.rd && r.bitn < 4'h7)
                begin
                    n.sda_oe = ~r.sh[7]; // RULE15
                    n.sh = {r.sh[6:0], 1'b0};
                end
                else if (r.rd)
                begin
                    n.sda_oe = 1'b0;
                end
            end
        end
        if (srst)
        begin
            n = '0;
            n.st = I2CWC_IDLE;
            n.stat.wiper = WIPER_MIDSCALE; // RULE1
            n.stat.nvcopy = WIPER_MIDSCALE; // RULE1
            n.stat.wprot = 1'b0; // RULE24
            n.scl_s = 3'b111;
            n.sda_s = 3'b111;
            // tap stays one-hot through reset
            n.taps = 256'(1) << WIPER_MIDSCALE; // RULE2
        end
    end

    always_ff @(posedge clk_sys)
    begin
        r <= n;
    end

    // open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = r.sda_oe;
    assign tap_select = r.taps;
    assign status = r.stat;

    property p_tap_onehot;
        @(posedge clk_sys) disable iff (srst) $onehot(tap_select);
    endproperty
    a_tap_onehot: assert property (p_tap_onehot) else $error("tap select not one-hot"); // RULE2

    property p_mid_reset;
        @(posedge clk_sys) $fell(srst) |-> status.wiper == WIPER_MIDSCALE && !status.wprot;
    endproperty
    a_mid_reset: assert property (p_mid_reset) else $error("wiper not midscale after reset"); // RULE1

    property p_stop_idle;
        @(posedge clk_sys) disable iff (srst) stop_c |=> r.st == I2CWC_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not end frame"); // RULE16

    property p_start_run;
        @(posedge clk_sys) disable iff (srst) start_c && r.boot == 2'b11 |=> r.st == I2CWC_RUN && r.bitn == BIT_LAST;
    endproperty
    a_start_run: assert property (p_start_run) else $error("start not seen"); // RULE3

    property p_skip_quiet;
        @(posedge clk_sys) disable iff (srst) r.st == I2CWC_SKIP && !start_c |=> !sda_oe;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("sda driven while skipping"); // RULE27

    property p_drive_on_fall;
        @(posedge clk_sys) disable iff (srst) r.rd && $changed(sda_oe) && !$past(start_c) && !$past(stop_c)
            |-> $past(scl_fall);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("read bit changed off falling edge"); // RULE15

    property p_wprot_hold;
        @(posedge clk_sys) disable iff (srst) status.wprot && $past(status.wprot) && $changed(status.wiper)
            |-> r.cmd == CMD_RESTORE;
    endproperty
    a_wprot_hold: assert property (p_wprot_hold) else $error("wiper written under protection"); // RULE26

    property p_addr_fixed;
        @(posedge clk_sys) disable iff (srst) r.boot == 2'b11 && $past(r.boot) == 2'b11 |-> $stable(r.my_addr);
    endproperty
    a_addr_fixed: assert property (p_addr_fixed) else $error("address changed after capture"); // RULE5

    property p_nop_idle;
        @(posedge clk_sys) disable iff (srst) $fell(status.nv_read_power) |-> $past(r.sh[7:5]) == CMD_NOP;
    endproperty
    a_nop_idle: assert property (p_nop_idle) else $error("read power dropped without nop"); // RULE25

    // a byte has just ended in the address or write phase
    sequence s_byte_end;
        r.st == I2CWC_RUN && scl_fall && r.bitn == 4'h7 && !r.rd;
    endsequence

    sequence s_read_ack_bit;
        r.st == I2CWC_RUN && scl_rise && r.rd && r.bitn == BIT_ACK;
    endsequence

    property p_addr_ack;
        @(posedge clk_sys) disable iff (srst)
            s_byte_end ##0 (r.bytn == BYTE_ADDR && r.sh[7:1] == r.my_addr) |=> sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // RULE6

    property p_ack_release;
        @(posedge clk_sys) disable iff (srst)
            r.st == I2CWC_RUN && scl_fall && r.bitn == BIT_ACK && !r.rd |=> !sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock"); // RULE8

    property p_instr_refuse;
        @(posedge clk_sys) disable iff (srst)
            s_byte_end ##0 (r.bytn == BYTE_INSTR && r.sh[4:0] != 5'h00) |=> r.st == I2CWC_SKIP && !sda_oe;
    endproperty
    a_instr_refuse: assert property (p_instr_refuse) else $error("bad instruction accepted"); // RULE7

    property p_wprot_set;
        @(posedge clk_sys) disable iff (srst)
            s_byte_end ##0 (r.bytn == BYTE_DATA && r.cmd == CMD_WPROT) |=> status.wprot == $past(r.sh[0]);
    endproperty
    a_wprot_set: assert property (p_wprot_set) else $error("protect bit not taken from data lsb"); // RULE9

    property p_nack_end;
        @(posedge clk_sys) disable iff (srst) s_read_ack_bit ##0 r.sda_s[1] |=> r.st == I2CWC_SKIP && !sda_oe;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read went on after nack"); // RULE17

    property p_ack_more;
        @(posedge clk_sys) disable iff (srst) s_read_ack_bit ##0 !r.sda_s[1] |=> r.st == I2CWC_RUN;
    endproperty
    a_ack_more: assert property (p_ack_more) else $error("read stopped after master ack"); // RULE20
endmodule
`default_nettype wire

//--- hw/i2cwc_pkg.sv
// package for the i2c wiper control target
package i2cwc_pkg;
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    localparam logic [6:0] ADDR_PIN00 = 7'h18;
    localparam logic [6:0] ADDR_PIN10 = 7'h1A;
    localparam logic [6:0] ADDR_PIN01 = 7'h4C;
    localparam logic [6:0] ADDR_PIN11 = 7'h4E;
    localparam logic [2:0] CMD_WIPER = 3'h0;
    localparam logic [2:0] CMD_NVCOPY = 3'h1;
    localparam logic [2:0] CMD_WPROT = 3'h2;
    localparam logic [2:0] CMD_TOL = 3'h3;
    localparam logic [2:0] CMD_NOP = 3'h4;
    localparam logic [2:0] CMD_RESTORE = 3'h5;
    localparam logic [2:0] CMD_STORE = 3'h6;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h9;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    typedef enum logic [1:0] {
        I2CWC_IDLE = 2'b00,
        I2CWC_RUN = 2'b01,
        I2CWC_SKIP = 2'b10
    } i2cwc_state_t;

    typedef struct packed {
        logic [7:0] wiper;
        logic [7:0] nvcopy;
        logic wprot;
        logic nv_read_power;
    } i2cwc_status_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        i2cwc_state_t st;
        logic [3:0] bitn;
        logic [1:0] bytn;
        logic [7:0] sh;
        logic rd;
        logic [2:0] cmd;
        logic [6:0] my_addr;
        logic [1:0] pins1;
        logic [1:0] pins2;
        logic [1:0] boot;
        logic sda_oe;
        logic [255:0] taps;
        i2cwc_status_t stat;
    } i2cwc_regs_t;
endpackage

//--- tb/i2cwc_master.sv
// bus controller model for the wiper control target
`timescale 1ns/1ps
`default_nettype none
module i2cwc_master
(
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // idle bus: clock high, data left to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // long low phase first so an acking target lets go before the clock rises
    task automatic start();
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r, output logic n);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(ninth, n);
    endtask
    // data pulled low before the tenth clock, released while it is high
    task automatic stop();
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the i2c wiper control target
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import i2cwc_pkg::*;
    localparam logic [7:0] TOL = 8'h5A;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, sda_line;
    logic [255:0] tap_select;
    i2cwc_status_t status;
    logic [6:0] me;
    logic [7:0] v, r;
    int err_count = 0;
    int checks_done = 0;
    // open drain: any party pulling low wins
    assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
    always #20 clk_sys = ~clk_sys;
    i2cwc_top #(.TOLERANCE_BYTE(TOL)) u_dut (.clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin0(pin0), .addr_select_pin1(pin1),
        .tap_select(tap_select), .status(status));
    i2cwc_master u_mst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_tap(input logic [7:0] w);
        checks_done++;
        if (tap_select !== (256'h1 << w))
        begin
            err_count++;
            $display("Error %0t: tap select wrong for code %h", $time, w);
        end
    endtask
    function automatic logic [6:0] exp_addr(input logic p1, input logic p0);
        case ({p1, p0})
            2'b00: return ADDR_PIN00;
            2'b01: return ADDR_PIN01;
            2'b10: return ADDR_PIN10;
            default: return ADDR_PIN11;
        endcase
    endfunction
    task automatic do_reset(input logic p1, input logic p0);
        @(posedge clk_sys);
        srst <= 1'b1;
        pin1 <= p1;
        pin0 <= p0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        pin1 <= ~p1;
        pin0 <= ~p0;
        me = exp_addr(p1, p0);
    endtask
    task automatic send(input logic [7:0] b, input logic en);
        logic [7:0] x;
        logic n;
        u_mst.xfer(b, 1'b1, x, n);
        chk(8'(n), 8'(en));
    endtask
    task automatic wr(input logic [2:0] c, input logic [7:0] d, input logic hasd);
        u_mst.start();
        send({me, 1'b0}, 1'b0);
        send({c, 5'h00}, 1'b0);
        if (hasd)
            send(d, 1'b0);
        u_mst.stop();
    endtask
    task automatic rd(input logic [2:0] c, input int n, input logic [7:0] e);
        logic [7:0] x;
        logic k;
        u_mst.start();
        send({me, 1'b0}, 1'b0);
        send({c, 5'h00}, 1'b0);
        u_mst.start();
        send({me, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            u_mst.xfer(8'hFF, i == n - 1, x, k);
            chk(x, e);
        end
        u_mst.stop();
    endtask
    task automatic chk_st(input logic [7:0] w, input logic [7:0] nv, input logic wp, input logic pw);
        chk(status.wiper, w);
        chk(status.nvcopy, nv);
        chk(8'(status.wprot), 8'(wp));
        chk(8'(status.nv_read_power), 8'(pw));
        chk_tap(w);
    endtask
    initial
    begin
        v = 8'($urandom(61272));
        for (int p = 0; p < 4; p++)
        begin
            do_reset(p[1], p[0]);
            chk_st(WIPER_MIDSCALE, WIPER_MIDSCALE, 1'b0, 1'b0);
            u_mst.start();
            send({~me[6], me[5:0], 1'b0}, 1'b1);
            send(8'h00, 1'b1);
            u_mst.stop();
            v = 8'($urandom);
            wr(CMD_WIPER, v, 1'b1);
            chk_st(v, WIPER_MIDSCALE, 1'b0, 1'b0);
        end
        // burst with the extreme codes first
        u_mst.start();
        send({me, 1'b0}, 1'b0);
        send({CMD_WIPER, 5'h00}, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            v = (i < 2) ? {8{i[0]}} : 8'($urandom);
            send(v, 1'b0);
            chk(status.wiper, v);
            chk_tap(v);
        end
        u_mst.stop();
        rd(CMD_WIPER, 3, v);
        r = ~v;
        wr(CMD_NVCOPY, r, 1'b1);
        rd(CMD_NVCOPY, 1, r);
        wr(CMD_RESTORE, 8'h00, 1'b0);
        chk_st(r, r, 1'b0, 1'b1);
        wr(CMD_NOP, 8'h00, 1'b0);
        chk_st(r, r, 1'b0, 1'b0);
        wr(CMD_WIPER, v, 1'b1);
        wr(CMD_STORE, 8'h00, 1'b0);
        chk_st(v, v, 1'b0, 1'b0);
        wr(CMD_WPROT, 8'h01, 1'b1);
        wr(CMD_WIPER, r, 1'b1);
        wr(CMD_NVCOPY, r, 1'b1);
        chk_st(v, v, 1'b1, 1'b0);
        // only the low bit of the data counts
        wr(CMD_WPROT, 8'hFE, 1'b1);
        chk_st(v, v, 1'b0, 1'b0);
        rd(CMD_TOL, 2, TOL);
        rd(CMD_TOL, 1, TOL);
        // protection left on, then a mid-run reset must clear it
        wr(CMD_WPROT, 8'h01, 1'b1);
        chk(8'(status.wprot), 8'h01);
        do_reset(1'b1, 1'b0);
        chk_st(WIPER_MIDSCALE, WIPER_MIDSCALE, 1'b0, 1'b0);
        u_mst.start();
        send({me, 1'b0}, 1'b0);
        send({CMD_WIPER, 5'h04}, 1'b1);
        u_mst.stop();
        finish_test();
    end
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        $display("Error %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
